// ===== design/serial_flash_spi.sv
// serial bus front end with status word and write protection
//
// Function
// - accept mode 0 and mode 3 clocks
// - sample on rising, drive on falling edges
// - dual fast read drives both lines
// - pause starts when serial clock low
// - pause ends when serial clock low
// - pause floats output, freezes decoder state
// - reset disables all instructions
// - startup delay blocks write class instructions
// - write class needs latch set
// - latch set by enable, cleared afterwards
// - busy allows only status read
// - power down accepts only release
// - region protect bits written by status write
// - top/bottom select defaults to top
// - lock bit with low protect pin blocks
// - reserved bit reads zero
// - first byte after select is instruction
// - write class needs whole bytes
// - deselected output floats
`timescale 1ns/1ps
`include "serial_flash_regs.svh"
module serial_flash_spi
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYC,
  parameter int WRITE_CYCLES   = `WRITE_CYC
)
(
  // system
  input  wire logic                       clk,
  input  wire logic                       rst,
  // serial pins
  input  wire serial_flash_pkg::spi_in_t  pinIn,
  output serial_flash_pkg::spi_out_t      pinOut,
  // array side: data to send and status view
  input  wire logic [7:0]                 readData,
  output logic      [7:0]                 statusWord,
  output logic      [23:0]                addrOut,
  output logic                            writeStart
);
  import serial_flash_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  spi_in_t    syncA_q;
  spi_in_t    syncB_q;
  logic       sckPrev_q;
  logic       csPrev_q;
  // two flops on every pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncA_q <= '{csN: 1'b1, sck: 1'b0, ioIn: 1'b0, pauseN: 1'b1, wpN: 1'b1};
      syncB_q <= '{csN: 1'b1, sck: 1'b0, ioIn: 1'b0, pauseN: 1'b1, wpN: 1'b1};
    end
    else
    begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end
  // edge history of clock and select, from the second stage only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sckPrev_q <= 1'b0;
      csPrev_q  <= 1'b1;
    end
    else
    begin
      sckPrev_q <= syncB_q.sck;
      csPrev_q  <= syncB_q.csN;
    end
  end

  logic sckRise;
  logic sckFall;
  logic selected;
  // edges of the serial clock, either idle level
  assign sckRise  = syncB_q.sck & ~sckPrev_q;
  assign sckFall  = ~syncB_q.sck & sckPrev_q;
  assign selected = ~syncB_q.csN;

  // ************************************************************
  // pause handling
  // ************************************************************
  logic pause_q;
  logic pauseReq;
  assign pauseReq = ~syncB_q.pauseN;
  // change only when the clock is low or on its falling edge
  always_ff @(posedge clk)
  begin
    if (rst || !selected)
      pause_q <= 1'b0;
    else if (pauseReq && !pause_q && (!syncB_q.sck || sckFall))
      pause_q <= 1'b1;
    else if (!pauseReq && pause_q && (!syncB_q.sck || sckFall))
      pause_q <= 1'b0;
  end

  logic active;
  // clock and data ignored during pause
  assign active = selected & ~pause_q & ~(pauseReq & ~syncB_q.sck);

  // ************************************************************
  // startup lockout and internal busy timer
  // ************************************************************
  logic [$clog2(STARTUP_CYCLES+1)-1:0] startCnt_q;
  logic                                 startDone;
  assign startDone = (startCnt_q == ($clog2(STARTUP_CYCLES+1))'(STARTUP_CYCLES));
  // count from reset release
  always_ff @(posedge clk)
  begin
    if (rst)
      startCnt_q <= '0;
    else if (!startDone)
      startCnt_q <= startCnt_q + 1'b1;
  end

  logic [$clog2(WRITE_CYCLES+1)-1:0] busyCnt_q;
  logic                               busy;
  assign busy = (busyCnt_q != '0);

  // ************************************************************
  // instruction decoder
  // ************************************************************
  phase_t      phase_q;
  logic [7:0]  shift_q;
  logic [2:0]  bitCnt_q;
  logic [7:0]  opcode_q;
  logic [1:0]  addrCnt_q;
  logic [23:0] addr_q;
  logic [7:0]  wrByte_q;
  logic        wholeByte_q;
  logic        powerDown_q;
  logic        deselEdge;
  logic        selEdge;
  logic [7:0]  inByte;
  assign inByte    = {shift_q[6:0], syncB_q.ioIn};
  assign deselEdge = syncB_q.csN & ~csPrev_q;
  assign selEdge   = ~syncB_q.csN & csPrev_q;

  // true for program, erase and status write opcodes
  function automatic logic isWriteClass(input logic [7:0] op);
    isWriteClass = (op == `OP_WRSR) || (op == `OP_PP) || (op == `OP_SE) ||
                   (op == `OP_BE) || (op == `OP_CE);
  endfunction : isWriteClass

  // true when three address bytes follow the opcode
  function automatic logic needsAddr(input logic [7:0] op);
    needsAddr = (op == `OP_READ) || (op == `OP_FAST) || (op == `OP_DUAL) ||
                (op == `OP_PP) || (op == `OP_SE) || (op == `OP_BE);
  endfunction : needsAddr

  // whether an opcode is accepted in the present state
  function automatic logic accepted(input logic [7:0] op, input logic bsy, input logic pd,
                                    input logic sd, input logic latch);
    if (pd)
      accepted = (op == `OP_RPD);
    else if (bsy)
      accepted = (op == `OP_RDSR);
    else if (!sd && (isWriteClass(op) || op == `OP_WREN))
      accepted = 1'b0;
    else if (isWriteClass(op) && !latch)
      accepted = 1'b0;
    else
      accepted = 1'b1;
  endfunction : accepted

  // shift in on rising edges, msb first
  always_ff @(posedge clk)
  begin
    if (rst || selEdge)
    begin
      phase_q     <= ST_CMD;
      shift_q     <= 8'h00;
      bitCnt_q    <= 3'd0;
      opcode_q    <= 8'h00;
      addrCnt_q   <= 2'd0;
      addr_q      <= 24'h000000;
      wrByte_q    <= 8'h00;
      wholeByte_q <= 1'b1;
    end
    else if (active && sckRise)
    begin
      shift_q     <= inByte;
      bitCnt_q    <= bitCnt_q + 3'd1;
      wholeByte_q <= (bitCnt_q == 3'd7);
      if (bitCnt_q == 3'd7)
      begin
        unique case (phase_q)
          ST_CMD:
          begin
            opcode_q <= inByte;
            if (!accepted(inByte, busy, powerDown_q, startDone, statusWord[`ST_LATCH_BIT]))
              phase_q <= ST_IGN;
            else if (needsAddr(inByte))
              phase_q <= ST_ADDR;
            else
              phase_q <= ST_DATA;
          end
          ST_ADDR:
          begin
            addr_q    <= {addr_q[15:0], inByte};
            addrCnt_q <= addrCnt_q + 2'd1;
            if (addrCnt_q == 2'd2)
              phase_q <= (opcode_q == `OP_FAST || opcode_q == `OP_DUAL) ? ST_DUMY : ST_DATA;
          end
          ST_DUMY:
            phase_q <= ST_DATA;
          ST_DATA:
            wrByte_q <= (opcode_q == `OP_WRSR && wrByte_q == 8'h00) ? inByte : wrByte_q;
          ST_IGN:
            phase_q <= ST_IGN;
        endcase
      end
    end
  end

  logic execWrite;
  logic doWrsr;
  logic cmdEnd;
  // a command only runs when select rises on a byte boundary
  assign cmdEnd    = deselEdge && wholeByte_q && (phase_q == ST_DATA);
  assign execWrite = cmdEnd && isWriteClass(opcode_q);
  assign doWrsr    = execWrite && (opcode_q == `OP_WRSR) &&
                     !(statusWord[`ST_LOCK_BIT] && !syncB_q.wpN);
  assign writeStart = execWrite && (opcode_q != `OP_WRSR);
  assign addrOut    = addr_q;

  // ************************************************************
  // status word
  // ************************************************************
  logic       writeLatch_q;
  logic [2:0] regionProt_q;
  logic       regionFromBottom_q;
  logic       statusLock_q;
  // busy timer for program, erase and status write
  always_ff @(posedge clk)
  begin
    if (rst)
      busyCnt_q <= '0;
    else if (doWrsr || writeStart)
      busyCnt_q <= ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES);
    else if (busy)
      busyCnt_q <= busyCnt_q - 1'b1;
  end
  // write enable latch
  always_ff @(posedge clk)
  begin
    if (rst)
      writeLatch_q <= 1'b0;
    else if (cmdEnd && opcode_q == `OP_WREN)
      writeLatch_q <= 1'b1;
    else if ((cmdEnd && opcode_q == `OP_WRDI) || (busyCnt_q == 1))
      writeLatch_q <= 1'b0;
  end
  // protection fields, only these change on a status write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      regionProt_q       <= 3'b000;
      regionFromBottom_q <= 1'b0;
      statusLock_q       <= 1'b0;
    end
    else if (doWrsr)
    begin
      regionProt_q       <= wrByte_q[`ST_RP_MSB:`ST_RP_LSB];
      regionFromBottom_q <= wrByte_q[`ST_BOTTOM_BIT];
      statusLock_q       <= wrByte_q[`ST_LOCK_BIT];
    end
  end
  // power down entry and release
  always_ff @(posedge clk)
  begin
    if (rst)
      powerDown_q <= 1'b0;
    else if (cmdEnd && opcode_q == `OP_PD)
      powerDown_q <= 1'b1;
    else if (cmdEnd && opcode_q == `OP_RPD)
      powerDown_q <= 1'b0;
  end

  assign statusWord = {statusLock_q, 1'b0, regionFromBottom_q, regionProt_q, writeLatch_q, busy};

  // ************************************************************
  // output shifter
  // ************************************************************
  logic [7:0] outByte_q;
  logic       soBit_q;
  logic       ioBit_q;
  logic       dualDrive;
  logic       reading;
  assign reading   = (phase_q == ST_DATA) && (opcode_q == `OP_RDSR || opcode_q == `OP_READ ||
                     opcode_q == `OP_FAST || opcode_q == `OP_DUAL);
  assign dualDrive = reading && (opcode_q == `OP_DUAL);
  // shift out on falling edges
  always_ff @(posedge clk)
  begin
    if (rst || !selected)
    begin
      outByte_q <= 8'h00;
      soBit_q   <= 1'b0;
      ioBit_q   <= 1'b0;
    end
    else if (active && sckFall && reading)
    begin
      if (dualDrive)
      begin
        ioBit_q   <= (bitCnt_q[1:0] == 2'b00) ? readData[7] : outByte_q[7]; // four clocks per byte
        soBit_q   <= (bitCnt_q[1:0] == 2'b00) ? readData[6] : outByte_q[6];
        outByte_q <= (bitCnt_q[1:0] == 2'b00) ? {readData[5:0], 2'b00} : {outByte_q[5:0], 2'b00};
      end
      else
      begin
        soBit_q   <= (bitCnt_q == 3'd0) ? ((opcode_q == `OP_RDSR) ? statusWord[7] : readData[7]) : outByte_q[7];
        outByte_q <= (bitCnt_q == 3'd0) ? {((opcode_q == `OP_RDSR) ? statusWord[6:0] : readData[6:0]), 1'b0}
                                        : {outByte_q[6:0], 1'b0};
      end
    end
  end

  // output enables off when deselected or paused
  assign pinOut = '{soOut: soBit_q, soOe: selected && !pause_q && reading,
                    ioOut: ioBit_q, ioOe: selected && !pause_q && dualDrive};

endmodule : serial_flash_spi

// ===== design/serial_flash_regs.svh
// status word layout, opcodes and timing constants of the serial flash front end
`ifndef SERIAL_FLASH_REGS_SVH
`define SERIAL_FLASH_REGS_SVH
// status word bit positions
`define ST_BUSY_BIT      0
`define ST_LATCH_BIT     1
`define ST_RP_LSB        2
`define ST_RP_MSB        4
`define ST_BOTTOM_BIT    5
`define ST_RSVD_BIT      6
`define ST_LOCK_BIT      7
`define ST_RESET         8'h00
// instruction codes
`define OP_WREN          8'h06
`define OP_WRDI          8'h04
`define OP_RDSR          8'h05
`define OP_WRSR          8'h01
`define OP_READ          8'h03
`define OP_FAST          8'h0B
`define OP_DUAL          8'h3B
`define OP_PP            8'h02
`define OP_SE            8'h20
`define OP_BE            8'hD8
`define OP_CE            8'hC7
`define OP_PD            8'hB9
`define OP_RPD           8'hAB
// timing: startup lockout and internal operation times
`define STARTUP_US       10
`define WRITE_US         10
`define CLK_MHZ          200
`define STARTUP_CYC      (`STARTUP_US * `CLK_MHZ)
`define WRITE_CYC        (`WRITE_US * `CLK_MHZ)
`endif

// ===== design/serial_flash_pkg.sv
// types shared by the serial flash front end
package serial_flash_pkg;
  // serial pins from the bus master
  typedef struct packed {
    logic csN;
    logic sck;
    logic ioIn;
    logic pauseN;
    logic wpN;
  } spi_in_t;
  // serial output drivers
  typedef struct packed {
    logic soOut;
    logic soOe;
    logic ioOut;
    logic ioOe;
  } spi_out_t;
  // instruction decoder state
  typedef enum logic [2:0] {
    ST_CMD  = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMY = 3'b010,
    ST_DATA = 3'b011,
    ST_IGN  = 3'b100
  } phase_t;
endpackage : serial_flash_pkg

// ===== dv/serial_flash_spi_props.sv
// assertions on the serial flash front end ports
`timescale 1ns/1ps
module serial_flash_spi_props
#(
  parameter int STARTUP_CYCLES = 20,
  parameter int WRITE_CYCLES   = 20
)
(
  // watched ports
  input wire logic                       clk,
  input wire logic                       rst,
  input wire serial_flash_pkg::spi_in_t  pinIn,
  input wire serial_flash_pkg::spi_out_t pinOut,
  input wire logic [7:0]                 readData,
  input wire logic [7:0]                 statusWord,
  input wire logic [23:0]                addrOut,
  input wire logic                       writeStart
);
  import serial_flash_pkg::*;
  int upCnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles since reset release, saturating
  always_ff @(posedge clk)
    if (rst) upCnt_q <= 0;
    else if (upCnt_q < STARTUP_CYCLES) upCnt_q <= upCnt_q + 1;
  sequence s_idle;
    pinIn.csN [*6];
  endsequence
  sequence s_paused;
    (!pinIn.csN && !pinIn.pauseN && !pinIn.sck) [*6];
  endsequence
  property p_desel;
    s_idle |-> !pinOut.soOe && !pinOut.ioOe;
  endproperty
  property p_pause;
    s_paused |-> !pinOut.soOe && !pinOut.ioOe;
  endproperty
  property p_rsvd;
    statusWord[6] == 1'b0;
  endproperty
  property p_rst;
    $fell(rst) |-> statusWord[1:0] == 2'b00 && !pinOut.soOe;
  endproperty
  property p_start;
    upCnt_q < STARTUP_CYCLES |-> !statusWord[1];
  endproperty
  property p_busyLen;
    $rose(statusWord[0]) |-> statusWord[0] [*8];
  endproperty
  property p_busyEnd;
    $fell(statusWord[0]) |-> ##[0:2] !statusWord[1];
  endproperty
  property p_wsLatch;
    writeStart |-> statusWord[1] ##1 !writeStart;
  endproperty
  property p_lock;
    statusWord[7] && !pinIn.wpN |=> $stable(statusWord[7:2]);
  endproperty
  a_desel: assert property (p_desel) else $error("output driven while deselected");
  a_pause: assert property (p_pause) else $error("output driven while paused");
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  a_rst: assert property (p_rst) else $error("state left after reset");
  a_start: assert property (p_start) else $error("latch set in startup lockout");
  a_busyLen: assert property (p_busyLen) else $error("busy too short");
  a_busyEnd: assert property (p_busyEnd) else $error("latch kept after busy");
  a_wsLatch: assert property (p_wsLatch) else $error("write start without latch");
  a_lock: assert property (p_lock) else $error("locked status word changed");
endmodule : serial_flash_spi_props
bind serial_flash_spi serial_flash_spi_props
#(.STARTUP_CYCLES(STARTUP_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) serial_flash_spi_props_i
(.clk(clk), .rst(rst), .pinIn(pinIn), .pinOut(pinOut), .readData(readData),
 .statusWord(statusWord), .addrOut(addrOut), .writeStart(writeStart));

// ===== dv/spi_master_model.sv
// bus master model driving the serial flash pins
`timescale 1ns/1ps
module spi_master_model
(
  // system clock paces the serial clock
  input  wire logic clk,
  // serial lines
  output logic      csN,
  output logic      sck,
  output logic      ioOut,
  output logic      pauseN,
  input  wire logic soIn,
  input  wire logic ioIn
);
  logic       idleHigh;
  int         pauseAt;
  logic [7:0] rxSo;
  logic [7:0] rxIo;
  // idle bus in mode 0
  initial
  begin
    idleHigh = 1'b0;
    pauseAt = -1;
    csN = 1'b1;
    sck = 1'b0;
    ioOut = 1'b0;
    pauseN = 1'b1;
  end
  // half serial period, 160 ns clock
  task half;
    repeat (16) @(negedge clk);
  endtask : half
  // one frame msb first, optional pause after bit pauseAt
  task frame(input logic [47:0] bits, input int nBits);
    sck = idleHigh;
    half();
    csN = 1'b0;
    half();
    for (int i = 0; i < nBits; i++)
    begin
      sck = 1'b0;
      ioOut = bits[47-i];
      half();
      sck = 1'b1;
      rxSo = {rxSo[6:0], soIn};
      rxIo = {rxIo[6:0], ioIn};
      half();
      if (i == pauseAt)
      begin
        sck = 1'b0;
        half();
        pauseN = 1'b0;
        half();
        repeat (4)
        begin
          sck = ~sck;
          ioOut = ~ioOut;
          half();
        end
        pauseN = 1'b1;
        half();
      end
    end
    sck = idleHigh;
    half();
    csN = 1'b1;
    ioOut = ~ioOut;
    half();
  endtask : frame
endmodule : spi_master_model

// ===== dv/test_serial_flash_spi.sv
// testbench of the serial flash front end
`timescale 1ns/1ps
`include "serial_flash_regs.svh"
module test_serial_flash_spi;
  import serial_flash_pkg::*;
  logic       clk;
  logic       rst;
  logic       wpN;
  logic       csN;
  logic       sck;
  logic       mIo;
  logic       pauseN;
  logic       ioLine;
  logic [7:0] readData;
  logic [7:0] statusWord;
  logic [23:0] addrOut;
  logic       writeStart;
  spi_in_t    pinIn;
  spi_out_t   pinOut;
  int         mismatches;
  int         n_compared;
  int         starts;
  logic [7:0] ops [4] = '{`OP_PP, `OP_SE, `OP_BE, `OP_CE};
  // shared data line: device wins when it drives
  assign ioLine = pinOut.ioOe ? pinOut.ioOut : mIo;
  assign pinIn = {csN, sck, ioLine, pauseN, wpN};
  serial_flash_spi #(.STARTUP_CYCLES(1500), .WRITE_CYCLES(400)) serial_flash_spi_i
  (.clk(clk), .rst(rst), .pinIn(pinIn), .pinOut(pinOut), .readData(readData),
   .statusWord(statusWord), .addrOut(addrOut), .writeStart(writeStart));
  spi_master_model spi_master_model_i
  (.clk(clk), .csN(csN), .sck(sck), .ioOut(mIo), .pauseN(pauseN), .soIn(pinOut.soOut), .ioIn(ioLine));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count start pulses away from the edge that launches them
  always @(negedge clk)
    if (writeStart === 1'b1) starts++;
  task test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask : check
  task send(input logic [47:0] bits, input int n);
    spi_master_model_i.frame(bits, n);
  endtask : send
  task status(input logic [7:0] exp);
    send({`OP_RDSR, 40'h0}, 16);
    check("status read", exp, spi_master_model_i.rxSo);
    check("statusWord", exp, statusWord);
  endtask : status
  task waitIdle;
    for (int i = 0; i < 1000 && statusWord[0] !== 1'b0; i++) @(negedge clk);
    if (statusWord[0] !== 1'b0)
    begin
      mismatches++;
      test_done();
    end
  endtask : waitIdle
  // main sequence
  initial
  begin
    rst = 1'b1;
    wpN = 1'b1;
    readData = 8'hA5;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    send({`OP_WREN, 40'h0}, 8);
    check("lockout latch", 1'h0, statusWord[1]);
    repeat (1500) @(negedge clk);
    status(8'h00);
    send({`OP_WREN, 40'h0}, 7);
    status(8'h00);
    send({`OP_WREN, 40'h0}, 8);
    status(8'h02);
    send({`OP_WRDI, 40'h0}, 8);
    send({`OP_WRSR, 8'hFF, 32'h0}, 16);
    status(8'h00);
    send({`OP_WREN, 40'h0}, 8);
    send({`OP_WRSR, 8'hFF, 32'h0}, 16);
    check("busy", 1'h1, statusWord[0]);
    send({`OP_WREN, 40'h0}, 8);
    waitIdle();
    status(8'hBC);
    wpN = 1'b0;
    send({`OP_WREN, 40'h0}, 8);
    send({`OP_WRSR, 8'h00, 32'h0}, 16);
    waitIdle();
    check("locked", 6'h2F, statusWord[7:2]);
    wpN = 1'b1;
    send({`OP_WREN, 40'h0}, 8);
    send({`OP_WRSR, 8'h40, 32'h0}, 16);
    waitIdle();
    status(8'h00);
    spi_master_model_i.pauseAt = 3;
    send({`OP_WREN, 40'h0}, 8);
    spi_master_model_i.pauseAt = 10;
    status(8'h02);
    spi_master_model_i.pauseAt = -1;
    spi_master_model_i.idleHigh = 1'b1;
    send({`OP_WRDI, 40'h0}, 8);
    status(8'h00);
    spi_master_model_i.idleHigh = 1'b0;
    send({`OP_PD, 40'h0}, 8);
    send({`OP_WREN, 40'h0}, 8);
    send({`OP_RPD, 40'h0}, 8);
    status(8'h00);
    send({`OP_READ, 24'h123456, 16'h0}, 40);
    check("read byte", 8'hA5, spi_master_model_i.rxSo);
    check("address", 24'h123456, addrOut);
    send({`OP_DUAL, 24'h123456, 16'h0}, 44);
    check("dual so bits", 4'h3, spi_master_model_i.rxSo[3:0]);
    check("dual io bits", 4'hC, spi_master_model_i.rxIo[3:0]);
    send({`OP_FAST, 24'h000010, 16'h0}, 48);
    check("fast byte", 8'hA5, spi_master_model_i.rxSo);
    check("fast io line", 8'h00, spi_master_model_i.rxIo);
    send({`OP_PP, 24'h0, 16'h5A00}, 40);
    check("start without latch", 3'h0, starts);
    for (int k = 0; k < 4; k++)
    begin
      send({`OP_WREN, 40'h0}, 8);
      send({ops[k], 24'h0, 16'h5A00}, 40);
      waitIdle();
      status(8'h00);
    end
    check("starts", 3'h4, starts);
    send({`OP_WREN, 40'h0}, 8);
    rst = 1'b1;
    send({`OP_WREN, 40'h0}, 8);
    rst = 1'b0;
    check("reset status", 8'h00, statusWord);
    send({`OP_WREN, 40'h0}, 8);
    status(8'h00);
    test_done();
  end
endmodule : test_serial_flash_spi
